// >>> cfl_cfg.svh
`ifndef CFL_CFG_SVH
`define CFL_CFG_SVH
`define CFL_OFF_FLAGS 12'h000
`define CFL_OFF_ACC 12'h004
`define CFL_OFF_INDEX 12'h008
`define CFL_OFF_MEMOP 12'h00C
`define CFL_OFF_PC 12'h010
`define CFL_OFF_CMD 12'h014
`define CFL_OFF_STATUS 12'h018
`define CFL_BIT_V 7
`define CFL_BIT_H 4
`define CFL_BIT_I 3
`define CFL_BIT_N 2
`define CFL_BIT_Z 1
`define CFL_BIT_C 0
`define CFL_FLAGS_ONES 8'h60
`define CFL_FLAGS_RST 8'h68
`define CFL_DATA_RST 8'h00
`define CFL_PC_RST 16'h0000
`define CFL_PUSH_LAST 3'h4
`define CFL_POP_LAST 3'h5
`define CFL_IRQ_N 8
`define CFL_STK_DEPTH 32
`endif

// >>> cfl_pkg.sv
package cfl_pkg;
  typedef enum logic [3:0] {
    nop_op, add_op, add_carry_op, clear_operand_op, compare_accumulator_op,
    compare_index_op, complement_op, decimal_adjust_op, decrement_branch_nonzero_op,
    decrement_op, increment_op, exclusive_or_op, mask_clear_op, mask_set_op,
    interrupt_return_op, illegal_op
  } cfl_op_t;
  typedef enum logic [1:0] {dst_acc, dst_xlo, dst_xhi, dst_mem} cfl_dst_t;
  typedef struct packed {
    logic [7:0] rel;
    logic [1:0] adv;
    cfl_dst_t dst;
    cfl_op_t op;
  } cfl_cmd_t;
  typedef struct packed {
    logic [7:0] res;
    logic [7:0] f;
  } cfl_alu_t;
  typedef struct packed {
    logic valid;
    logic [2:0] num;
  } cfl_vec_t;
  typedef enum {st_idle, st_exec, st_push, st_mask, st_vector, st_pop} cfl_state_t;
endpackage

// >>> cfl_stack_mem.sv
`timescale 1ns/1ps
module cfl_stack_mem #(
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];

  // No reset on the array: stacked bytes are only read after being pushed.
  always_ff @(posedge ref_clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // cfl_stack_mem

// >>> cfl_core.sv
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "cfl_cfg.svh"
module cfl_core #(
  parameter int IRQ_N = `CFL_IRQ_N,
  parameter int STK_DEPTH = `CFL_STK_DEPTH
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [IRQ_N-1:0] irq_in,
  output cfl_pkg::cfl_vec_t vec_out,
  output logic busy
);
  import cfl_pkg::*;
  localparam int SAW = $clog2(STK_DEPTH);

  if (IRQ_N < 1 || IRQ_N > 8 || STK_DEPTH < 8 || (1 << SAW) != STK_DEPTH)
  begin : g_bad_param
    $error("cfl_core: IRQ_N must be 1..8 and STK_DEPTH a power of two of 8 or more");
  end

  logic [7:0] flags_reg;
  logic [7:0] acc_reg;
  logic [7:0] x_reg;
  logic [7:0] h_reg;
  logic [7:0] mem_reg;
  logic [15:0] pc_reg;
  cfl_cmd_t cmd_reg;
  cfl_state_t state_reg;
  logic [2:0] step_reg;
  logic [SAW-1:0] sp_reg;
  logic [IRQ_N-1:0] irq_s1_reg;
  logic [IRQ_N-1:0] irq_s2_reg;
  logic [2:0] vnum_reg;
  logic [31:0] prdata_reg;
  logic err_reg;
  logic [7:0] st_rdata;
  logic st_we;
  logic [SAW-1:0] st_addr;
  logic [7:0] st_wdata;
  logic [7:0] a_sel;
  cfl_alu_t alu_o;
  cfl_cmd_t wcmd;
  logic wr_acc;
  logic cmd_go;
  logic irq_go;
  logic [31:0] rd_next;
  logic [IRQ_N-1:0] pick_bit;

  function automatic logic [2:0] map_f(input logic [11:0] a);
    unique case (a)
      `CFL_OFF_FLAGS: map_f = 3'h1;
      `CFL_OFF_ACC: map_f = 3'h2;
      `CFL_OFF_INDEX: map_f = 3'h3;
      `CFL_OFF_MEMOP: map_f = 3'h4;
      `CFL_OFF_PC: map_f = 3'h5;
      `CFL_OFF_CMD: map_f = 3'h6;
      `CFL_OFF_STATUS: map_f = 3'h7;
      default: map_f = 3'h0;
    endcase
  endfunction

  // Lowest line index is the highest priority.
  function automatic logic [2:0] prio_f(input logic [IRQ_N-1:0] p);
    prio_f = 3'h0;
    for (int i = IRQ_N - 1; i >= 0; i--)
    begin
      if (p[i])
      begin
        prio_f = 3'(i);
      end
    end
  endfunction

  function automatic cfl_alu_t alu_f(input cfl_op_t op, input logic [7:0] a,
                                     input logic [7:0] m, input logic [7:0] f);
    cfl_alu_t o;
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] cor;
    logic nz;
    o.res = a;
    o.f = f;
    s = 9'h000;
    n = 5'h00;
    cor = 8'h00;
    nz = 1'b1;
    unique case (op)
      add_op, add_carry_op:
      begin
        n = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, (op == add_carry_op) & f[`CFL_BIT_C]};
        s = {1'b0, a} + {1'b0, m} + {8'h00, (op == add_carry_op) & f[`CFL_BIT_C]};
        o.res = s[7:0];
        o.f[`CFL_BIT_H] = n[4];
        o.f[`CFL_BIT_V] = (a[7] == m[7]) && (s[7] != a[7]);
        o.f[`CFL_BIT_C] = s[8];
      end
      compare_accumulator_op, compare_index_op:
      begin
        s = {1'b0, a} - {1'b0, m};
        o.res = s[7:0];
        o.f[`CFL_BIT_V] = (a[7] != m[7]) && (s[7] != a[7]);
        o.f[`CFL_BIT_C] = s[8];
      end
      clear_operand_op:
      begin
        o.res = 8'h00;
        o.f[`CFL_BIT_V] = 1'b0;
      end
      complement_op:
      begin
        o.res = 8'hFF - a;
        o.f[`CFL_BIT_V] = 1'b0;
        o.f[`CFL_BIT_C] = 1'b1;
      end
      decimal_adjust_op:
      begin
        if (f[`CFL_BIT_H] || a[3:0] > 4'h9)
        begin
          cor[3:0] = 4'h6;
        end
        if (f[`CFL_BIT_C] || a > 8'h99)
        begin
          cor[7:4] = 4'h6;
          o.f[`CFL_BIT_C] = 1'b1;
        end
        o.res = a + cor;
      end
      decrement_branch_nonzero_op:
      begin
        o.res = a - 8'h01;
        nz = 1'b0;
      end
      decrement_op:
      begin
        o.res = a - 8'h01;
        o.f[`CFL_BIT_V] = (o.res == 8'h7F);
      end
      increment_op:
      begin
        o.res = a + 8'h01;
        o.f[`CFL_BIT_V] = (o.res == 8'h80);
      end
      exclusive_or_op:
      begin
        o.res = a ^ m;
        o.f[`CFL_BIT_V] = 1'b0;
      end
      default:
      begin
        nz = 1'b0;
      end
    endcase
    if (nz)
    begin
      o.f[`CFL_BIT_N] = o.res[7];
      o.f[`CFL_BIT_Z] = (o.res == 8'h00);
    end
    o.f = o.f | `CFL_FLAGS_ONES;
    return o;
  endfunction

  assign wcmd = cfl_cmd_t'(pwdata[15:0]);
  assign wr_acc = psel & penable & pwrite;
  assign cmd_go = wr_acc && (state_reg == st_idle) && (map_f(paddr) == 3'h6)
                  && (wcmd.op != illegal_op);
  // A command written in the same cycle wins; the request is taken once the core is back in st_idle.
  assign irq_go = (state_reg == st_idle) && !cmd_go && !flags_reg[`CFL_BIT_I]
                  && (|irq_s2_reg);
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_reg;
  assign prdata = prdata_reg;
  assign busy = (state_reg != st_idle);
  assign vec_out = {state_reg == st_vector, vnum_reg};

  always_comb
  begin
    unique case (cmd_reg.op)
      add_op, add_carry_op, compare_accumulator_op, decimal_adjust_op, exclusive_or_op:
        a_sel = acc_reg;
      compare_index_op:
        a_sel = x_reg;
      default:
        unique case (cmd_reg.dst)
          dst_acc: a_sel = acc_reg;
          dst_xlo: a_sel = x_reg;
          dst_xhi: a_sel = h_reg;
          dst_mem: a_sel = mem_reg;
        endcase
    endcase
    alu_o = alu_f(cmd_reg.op, a_sel, mem_reg, flags_reg);
  end

  always_comb
  begin
    unique case (map_f(paddr))
      3'h1: rd_next = {24'h000000, flags_reg | `CFL_FLAGS_ONES};
      3'h2: rd_next = {24'h000000, acc_reg};
      3'h3: rd_next = {16'h0000, h_reg, x_reg};
      3'h4: rd_next = {24'h000000, mem_reg};
      3'h5: rd_next = {16'h0000, pc_reg};
      3'h6: rd_next = {16'h0000, cmd_reg};
      3'h7: rd_next = {7'h00, busy, 5'h00, vnum_reg, 8'(irq_s2_reg), 8'(sp_reg)};
      default: rd_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prdata_reg <= 32'h00000000;
      err_reg <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata_reg <= rd_next;
      err_reg <= (map_f(paddr) == 3'h0);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_s1_reg <= '0;
      irq_s2_reg <= '0;
    end
    else
    begin
      irq_s1_reg <= irq_in;
      irq_s2_reg <= irq_s1_reg;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= st_idle;
      step_reg <= 3'h0;
      cmd_reg <= '0;
      vnum_reg <= 3'h0;
    end
    else
    begin
      unique case (state_reg)
        st_idle:
        begin
          step_reg <= 3'h0;
          if (cmd_go)
          begin
            cmd_reg <= wcmd;
            state_reg <= (wcmd.op == interrupt_return_op) ? st_pop : st_exec;
          end
          else if (irq_go)
          begin
            vnum_reg <= prio_f(irq_s2_reg);
            state_reg <= st_push;
          end
        end
        st_exec:
          state_reg <= st_idle;
        st_push:
        begin
          step_reg <= step_reg + 3'h1;
          if (step_reg == `CFL_PUSH_LAST)
          begin
            state_reg <= st_mask;
          end
        end
        st_mask:
          state_reg <= st_vector;
        st_vector:
          state_reg <= st_idle;
        st_pop:
        begin
          step_reg <= step_reg + 3'h1;
          if (step_reg == `CFL_POP_LAST)
          begin
            state_reg <= st_idle;
          end
        end
      endcase
    end
  end

  // Push order is PC low, PC high, index low, accumulator, flags; the index high byte
  // stays out so service routines that touch it must save it themselves.
  always_comb
  begin
    st_we = (state_reg == st_push);
    st_addr = sp_reg;
    st_wdata = flags_reg;
    if (state_reg == st_pop)
    begin
      st_addr = sp_reg + SAW'(step_reg) + SAW'(1);
    end
    unique case (step_reg)
      3'h0: st_wdata = pc_reg[7:0];
      3'h1: st_wdata = pc_reg[15:8];
      3'h2: st_wdata = x_reg;
      3'h3: st_wdata = acc_reg;
      default: st_wdata = flags_reg;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sp_reg <= '1;
    end
    else if (state_reg == st_push)
    begin
      sp_reg <= sp_reg - SAW'(1);
    end
    else if (state_reg == st_pop && step_reg == `CFL_POP_LAST)
    begin
      sp_reg <= sp_reg + SAW'(5);
    end
  end

  cfl_stack_mem #(
    .DEPTH(STK_DEPTH)
  ) cfl_stack_mem_i (
    .ref_clk(ref_clk),
    .we(st_we),
    .addr(st_addr),
    .wdata(st_wdata),
    .rdata(st_rdata)
  );

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flags_reg <= `CFL_FLAGS_RST;
    end
    else if (state_reg == st_idle && wr_acc && map_f(paddr) == 3'h1)
    begin
      flags_reg <= pwdata[7:0] | `CFL_FLAGS_ONES | {4'h0, flags_reg[`CFL_BIT_I], 3'h0};
    end
    else if (state_reg == st_exec)
    begin
      unique case (cmd_reg.op)
        mask_clear_op: flags_reg[`CFL_BIT_I] <= 1'b0;
        mask_set_op: flags_reg[`CFL_BIT_I] <= 1'b1;
        default: flags_reg <= alu_o.f;
      endcase
    end
    else if (state_reg == st_mask)
    begin
      flags_reg[`CFL_BIT_I] <= 1'b1;
    end
    else if (state_reg == st_pop && step_reg == 3'h1)
    begin
      flags_reg <= st_rdata | `CFL_FLAGS_ONES;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      acc_reg <= `CFL_DATA_RST;
      x_reg <= `CFL_DATA_RST;
      h_reg <= `CFL_DATA_RST;
      mem_reg <= `CFL_DATA_RST;
      pc_reg <= `CFL_PC_RST;
    end
    else if (state_reg == st_idle && wr_acc)
    begin
      unique case (map_f(paddr))
        3'h2: acc_reg <= pwdata[7:0];
        3'h3: {h_reg, x_reg} <= pwdata[15:0];
        3'h4: mem_reg <= pwdata[7:0];
        3'h5: pc_reg <= pwdata[15:0];
        default: acc_reg <= acc_reg;
      endcase
    end
    else if (state_reg == st_exec)
    begin
      unique case (cmd_reg.op)
        add_op, add_carry_op, decimal_adjust_op, exclusive_or_op:
          acc_reg <= alu_o.res;
        clear_operand_op, complement_op, decrement_op, increment_op,
        decrement_branch_nonzero_op:
          unique case (cmd_reg.dst)
            dst_acc: acc_reg <= alu_o.res;
            dst_xlo: x_reg <= alu_o.res;
            dst_xhi: h_reg <= alu_o.res;
            dst_mem: mem_reg <= alu_o.res;
          endcase
        default: acc_reg <= acc_reg;
      endcase
      if (cmd_reg.op == decrement_branch_nonzero_op)
      begin
        pc_reg <= pc_reg + {14'h0000, cmd_reg.adv} + 16'h0002
                  + ((alu_o.res != 8'h00) ? {{8{cmd_reg.rel[7]}}, cmd_reg.rel} : 16'h0000);
      end
    end
    else if (state_reg == st_pop)
    begin
      unique case (step_reg)
        3'h2: acc_reg <= st_rdata;
        3'h3: x_reg <= st_rdata;
        3'h4: pc_reg[15:8] <= st_rdata;
        3'h5: pc_reg[7:0] <= st_rdata;
        default: acc_reg <= acc_reg;
      endcase
    end
  end

  a_flag_ones: assert property (@(posedge ref_clk) disable iff (sys_rst)
    flags_reg[6:5] == 2'b11) else $error("flag bits 6 and 5 not one");
  a_mask_holds: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_reg == st_idle && flags_reg[`CFL_BIT_I]) |=> state_reg != st_push)
    else $error("request accepted while masked");
  a_entry_order: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_reg == st_push && step_reg == 3'h4) |=> state_reg == st_mask
    ##1 (state_reg == st_vector && flags_reg[`CFL_BIT_I]))
    else $error("entry order broken");
  a_no_high_push: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(state_reg == st_push) |-> (state_reg == st_push)[*5] ##1 state_reg == st_mask)
    else $error("push count not five");
  // The chosen line must have been pending, and no line of lower index may have been.
  assign pick_bit = IRQ_N'(1) << vnum_reg;
  a_prio_pick: assert property (@(posedge ref_clk) disable iff (sys_rst)
    irq_go |=> (($past(irq_s2_reg) & pick_bit) != '0)
    && (($past(irq_s2_reg) & (pick_bit - IRQ_N'(1))) == '0))
    else $error("wrong priority chosen");
  a_pop_mask: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_reg == st_pop && step_reg == 3'h1) |=>
    flags_reg[`CFL_BIT_I] == $past(st_rdata[`CFL_BIT_I]))
    else $error("mask not restored");
  a_mask_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(flags_reg[`CFL_BIT_I]) |-> $past(state_reg == st_pop)
    || $past(state_reg == st_exec && cmd_reg.op == mask_clear_op))
    else $error("mask cleared without cause");
  a_add_half: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_reg == st_exec && cmd_reg.op == add_op) |=> flags_reg[`CFL_BIT_H] ==
    (({1'b0, $past(acc_reg[3:0])} + {1'b0, $past(mem_reg[3:0])}) > 5'h0F))
    else $error("half carry wrong");
  a_eor_flags: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_reg == st_exec && cmd_reg.op == exclusive_or_op) |=>
    !flags_reg[`CFL_BIT_V] && flags_reg[`CFL_BIT_C] == $past(flags_reg[`CFL_BIT_C])
    && flags_reg[`CFL_BIT_Z] == (acc_reg == 8'h00))
    else $error("exclusive-or flags wrong");
  a_decrement_branch_nonzero_op_keep: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_reg == st_exec && cmd_reg.op == decrement_branch_nonzero_op) |=>
    flags_reg == $past(flags_reg)) else $error("branch loop changed flags");
  a_cmp_borrow: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_reg == st_exec && cmd_reg.op == compare_accumulator_op) |=>
    flags_reg[`CFL_BIT_C] == ($past(mem_reg) > $past(acc_reg)) && acc_reg == $past(acc_reg))
    else $error("compare wrong");
  c_irq_entry: cover property (@(posedge ref_clk) disable iff (sys_rst)
    state_reg == st_vector);
  c_irq_return: cover property (@(posedge ref_clk) disable iff (sys_rst)
    state_reg == st_pop && step_reg == 3'h5);
  c_branch_taken: cover property (@(posedge ref_clk) disable iff (sys_rst)
    state_reg == st_exec && cmd_reg.op == decrement_branch_nonzero_op && alu_o.res != 8'h00);
endmodule // cfl_core

// >>> cfl_core_test.sv
`timescale 1ns/1ps
`include "cfl_cfg.svh"
module cfl_core_test;
  import cfl_pkg::*;
  localparam int DEPTH = 32;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] irq_in = 8'h00;
  cfl_vec_t vec_out;
  logic busy;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  int vec_pulses = 0;
  logic [31:0] rd;
  logic serr;

  cfl_core #(.IRQ_N(8), .STK_DEPTH(DEPTH)) cfl_core_i (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irq_in(irq_in),
    .vec_out(vec_out),
    .busy(busy)
  );

  always #2.5 ref_clk = ~ref_clk;

  // The cycle ceiling is far above the few hundred cycles the sequence needs.
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (vec_out.valid === 1'b1)
      vec_pulses <= vec_pulses + 1;
    if (cycles == 20000)
    begin
      err_total = err_total + 1;
      $display("MISMATCH at %0t: run did not finish in time", $time);
      results();
    end
  end

  task automatic results();
    $display("Mismatches: %0d, comparisons: %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Read data and the error flag are taken at the edge that samples pready high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input cfl_op_t op, input cfl_dst_t dst, input logic [1:0] adv,
    input logic [7:0] rel);
    cfl_cmd_t c;
    c.op = op;
    c.dst = dst;
    c.adv = adv;
    c.rel = rel;
    apb(1'b1, `CFL_OFF_CMD, {16'h0, c});
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (2) @(posedge ref_clk);
    #1;
    while (busy !== 1'b0 && n < 50)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk({31'h0, busy}, 32'h0, "busy after command");
  endtask

  // Operand a goes to both the accumulator and the index low byte, so either can be checked.
  task automatic run_op(input cfl_op_t op, input cfl_dst_t dst, input logic [7:0] a,
    input logic [7:0] m, input logic [7:0] fin, input logic [7:0] res, input logic [7:0] fexp);
    apb(1'b1, `CFL_OFF_ACC, {24'h0, a});
    apb(1'b1, `CFL_OFF_INDEX, {24'h0, a});
    apb(1'b1, `CFL_OFF_MEMOP, {24'h0, m});
    apb(1'b1, `CFL_OFF_FLAGS, {24'h0, fin});
    cmd(op, dst, 2'h0, 8'h00);
    wait_idle();
    apb(1'b0, dst == dst_mem ? `CFL_OFF_MEMOP : dst == dst_xlo ? `CFL_OFF_INDEX : `CFL_OFF_ACC,
      32'h0);
    chk(rd, {24'h0, res}, "result");
    apb(1'b0, `CFL_OFF_FLAGS, 32'h0);
    chk(rd, {24'h0, fexp}, "flags");
  endtask

  task automatic run_decrement_branch_nonzero_op(input logic [1:0] adv, input logic [7:0] rel, input logic [7:0] a,
    input logic [15:0] pc_exp);
    apb(1'b1, `CFL_OFF_PC, 32'h00000100);
    apb(1'b1, `CFL_OFF_ACC, {24'h0, a});
    apb(1'b1, `CFL_OFF_FLAGS, 32'h0000006D);
    cmd(decrement_branch_nonzero_op, dst_acc, adv, rel);
    wait_idle();
    apb(1'b0, `CFL_OFF_PC, 32'h0);
    chk(rd, {16'h0, pc_exp}, "program counter");
    apb(1'b0, `CFL_OFF_ACC, 32'h0);
    chk(rd, {24'h0, a - 8'h01}, "decremented operand");
    apb(1'b0, `CFL_OFF_FLAGS, 32'h0);
    chk(rd, 32'h0000006D, "flags kept");
  endtask

  // Line 2 outranks line 5; the handler clobbers the high index byte, which must stay clobbered.
  task automatic irq_test();
    int n;
    apb(1'b1, `CFL_OFF_PC, 32'h00001234);
    apb(1'b1, `CFL_OFF_ACC, 32'h00000055);
    apb(1'b1, `CFL_OFF_INDEX, 32'h0000AB77);
    apb(1'b1, `CFL_OFF_FLAGS, 32'h00000069);
    irq_in <= 8'h24;
    repeat (20) @(posedge ref_clk);
    chk(vec_pulses, 32'h0, "vector while masked");
    cmd(mask_clear_op, dst_acc, 2'h0, 8'h00);
    n = 0;
    while (vec_out.valid !== 1'b1 && n < 40)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk({29'h0, vec_out.num}, 32'h2, "accepted line");
    irq_in <= 8'h00;
    wait_idle();
    chk(vec_pulses, 32'h1, "vector pulses after entry");
    apb(1'b0, `CFL_OFF_FLAGS, 32'h0);
    chk(rd, 32'h00000069, "mask set on entry");
    apb(1'b0, `CFL_OFF_STATUS, 32'h0);
    chk({24'h0, rd[7:0]}, DEPTH - 6, "stack after entry");
    apb(1'b1, `CFL_OFF_INDEX, 32'h0000C300);
    apb(1'b1, `CFL_OFF_ACC, 32'h0);
    apb(1'b1, `CFL_OFF_PC, 32'h0);
    cmd(interrupt_return_op, dst_acc, 2'h0, 8'h00);
    wait_idle();
    apb(1'b0, `CFL_OFF_FLAGS, 32'h0);
    chk(rd, 32'h00000061, "restored flags");
    apb(1'b0, `CFL_OFF_ACC, 32'h0);
    chk(rd, 32'h00000055, "restored accumulator");
    apb(1'b0, `CFL_OFF_INDEX, 32'h0);
    chk(rd, 32'h0000C377, "index after return");
    apb(1'b0, `CFL_OFF_PC, 32'h0);
    chk(rd, 32'h00001234, "restored program counter");
    apb(1'b0, `CFL_OFF_STATUS, 32'h0);
    chk({24'h0, rd[7:0]}, DEPTH - 1, "stack after return");
  endtask

  // Mask set and clear by command, then a reset in mid-run must set the mask again.
  task automatic mask_reset_test();
    cmd(mask_set_op, dst_acc, 2'h0, 8'h00);
    wait_idle();
    apb(1'b0, `CFL_OFF_FLAGS, 32'h0);
    chk(rd, 32'h00000069, "mask set by command");
    cmd(mask_clear_op, dst_acc, 2'h0, 8'h00);
    wait_idle();
    apb(1'b0, `CFL_OFF_FLAGS, 32'h0);
    chk(rd, 32'h00000061, "mask cleared by command");
    apb(1'b1, `CFL_OFF_ACC, 32'h000000A5);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    apb(1'b0, `CFL_OFF_FLAGS, 32'h0);
    chk(rd, 32'h00000068, "flags after mid-run reset");
    apb(1'b0, `CFL_OFF_ACC, 32'h0);
    chk(rd, 32'h0, "accumulator after mid-run reset");
    apb(1'b0, `CFL_OFF_STATUS, 32'h0);
    chk({24'h0, rd[7:0]}, DEPTH - 1, "stack after mid-run reset");
  endtask

  initial
  begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    apb(1'b0, `CFL_OFF_FLAGS, 32'h0);
    chk(rd, 32'h00000068, "flags at reset");
    chk({31'h0, serr}, 32'h0, "no error on mapped read");
    apb(1'b1, `CFL_OFF_FLAGS, 32'h0);
    apb(1'b0, `CFL_OFF_FLAGS, 32'h0);
    chk(rd, 32'h00000068, "flags after zero write");
    apb(1'b0, 12'h01C, 32'h0);
    chk({31'h0, serr}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    run_op(add_op, dst_acc, 8'h0F, 8'h01, 8'h68, 8'h10, 8'h78);
    run_op(add_op, dst_acc, 8'h7F, 8'h01, 8'h68, 8'h80, 8'hFC);
    run_op(add_carry_op, dst_acc, 8'hFF, 8'h00, 8'h69, 8'h00, 8'h7B);
    run_op(clear_operand_op, dst_mem, 8'h11, 8'h33, 8'hFF, 8'h00, 8'h7B);
    run_op(compare_accumulator_op, dst_acc, 8'h10, 8'h20, 8'h78, 8'h10, 8'h7D);
    run_op(compare_accumulator_op, dst_acc, 8'h80, 8'h01, 8'h68, 8'h80, 8'hE8);
    run_op(compare_index_op, dst_xlo, 8'h05, 8'h05, 8'h69, 8'h05, 8'h6A);
    run_op(complement_op, dst_mem, 8'h0F, 8'h0F, 8'hE8, 8'hF0, 8'h6D);
    run_op(decimal_adjust_op, dst_acc, 8'h9A, 8'h00, 8'h68, 8'h00, 8'h6B);
    run_op(decimal_adjust_op, dst_acc, 8'h12, 8'h00, 8'h78, 8'h18, 8'h78);
    run_op(decrement_op, dst_xlo, 8'h80, 8'h00, 8'h69, 8'h7F, 8'hE9);
    run_op(increment_op, dst_acc, 8'hFF, 8'h00, 8'h6C, 8'h00, 8'h6A);
    run_op(exclusive_or_op, dst_acc, 8'h5A, 8'hA5, 8'hF9, 8'hFF, 8'h7D);
    run_op(illegal_op, dst_acc, 8'h44, 8'h01, 8'h69, 8'h44, 8'h69);
    run_decrement_branch_nonzero_op(2'h2, 8'hFE, 8'h02, 16'h0102);
    run_decrement_branch_nonzero_op(2'h0, 8'h10, 8'h01, 16'h0102);
    run_decrement_branch_nonzero_op(2'h1, 8'h80, 8'h00, 16'h0083);
    irq_test();
    mask_reset_test();
    results();
  end
endmodule // cfl_core_test
